// ===== scsirq_pkg.sv
// package: register map, field positions and reset values of the channel status/irq bank
package scsirq_pkg;
	localparam logic [7:0] TX_SLOT_SELECT_OFS   = 8'h30;
	localparam logic [7:0] RX_SLOT_SELECT_OFS   = 8'h31;
	localparam logic [7:0] TX_SLOT_CAPACITY_OFS = 8'h32;
	localparam logic [7:0] RX_SLOT_CAPACITY_OFS = 8'h33;
	localparam logic [7:0] REV_STATUS_OFS       = 8'h34;
	localparam logic [7:0] GLOBAL_SUMMARY_OFS   = 8'h38;
	localparam logic [7:0] IRQ_OUTPUT_CFG_OFS   = 8'h39;
	localparam logic [7:0] RX_EVENT_STATUS_OFS  = 8'h3a;
	localparam logic [7:0] CHAN_B_OFS           = 8'h40;
	localparam logic [7:0] CHAN_CONFIG1_OFS     = 8'h2d;
	localparam logic [7:0] CHAN_CONFIG2_OFS     = 8'h2e;
	localparam logic [7:0] CHAN_CONFIG3_OFS     = 8'h2f;
	localparam logic [7:0] MASK_REG0_OFS        = 8'h3a;
	localparam logic [7:0] EXT_STATUS_OFS       = 8'h3f;
	localparam logic [7:0] REG_RESET            = 8'h00;
	localparam logic [7:0] MASK_RESET           = 8'hff;
	localparam logic [2:0] CLOCK_MODE_SLOT      = 3'h5;
	localparam int         EV_THRESHOLD = 0;
	localparam int         EV_OVERFLOW  = 1;
	localparam int         EV_CARRIER   = 2;
	localparam int         EV_LOCK_LOST = 3;
	localparam int         EV_SYNC      = 4;
	localparam int         EV_PARITY    = 5;
	localparam int         EV_TERM      = 7;
endpackage : scsirq_pkg

// ===== scsirq_regs.sv
// channel A register bank: slot assignment, baud divisor, status and shared interrupt logic
// Function
// - crc polynomial chosen by select bit
// - phase shift off widens adjust windows
// - six-bit tx and rx slot numbers
// - offset from slot reg and config bit
// - slot settings used in mode five only
// - bits per slot equal count plus one
// - live carrier level, change sets status
// - lock loss flags, idles rx, halts tx when that clock comes from recovery
// - baud divide by (n plus one) times two
// - summary bits for pending status registers
// - summary clears when source read or vector clears its last bits
// - shared registers at both channel addresses
// - vector base on data bits seven..three
// - masked events recorded when visible set
// - slave cascade acknowledge on id match
// - daisy chain acknowledge, enable out low
// - output stage open drain or push-pull
// - read clears all, vector clears two
// - termination status on char with short block
// - sync found in hunt enters sync
// - threshold in interrupt mode, overflow full
// - offset shifts slot zero to seven clocks
// - mask bit blocks vector, output, summary
`timescale 1ns/1ns
`default_nettype none
module scsirq_regs
	import scsirq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              carrier_sense,
	input  wire logic              recovery_unlocked,
	input  wire logic              rx_clk_from_recovery,
	input  wire logic              tx_clk_from_recovery,
	input  wire logic              term_char_in,
	input  wire logic              short_block,
	input  wire logic              hunt_mode,
	input  wire logic              sync_char_in,
	input  wire logic              parity_fault_in,
	input  wire logic              queue_at_threshold,
	input  wire logic              queue_full,
	input  wire logic              char_arrived,
	input  wire logic              interrupt_mode,
	input  wire logic              chan_a_status1_in,
	input  wire logic              chan_b_status0_in,
	input  wire logic              chan_b_status1_in,
	input  wire logic              port_irq_in,
	input  wire logic              irq_ack,
	input  wire logic              enable_pin_zero,
	input  wire logic              enable_pin_one,
	output logic                   chain_enable_out,
	output logic                   irq_out,
	output logic                   irq_oe,
	output logic                   ack_vector_oe,
	output logic      [7:0]        ack_vector,
	output logic                   poly_ccitt,
	output logic                   phase_shift_off,
	output logic                   slot_mode_on,
	output logic      [5:0]        tx_slot_number,
	output logic      [5:0]        rx_slot_number,
	output logic      [2:0]        tx_offset,
	output logic      [2:0]        rx_offset,
	output logic      [8:0]        tx_slot_bits,
	output logic      [8:0]        rx_slot_bits,
	output logic      [11:0]       baud_divide,
	output logic                   rx_idle_fill,
	output logic                   tx_halt,
	output logic                   sync_state
);
	import scsirq_pkg::*;

	logic [7:0] tx_slot_select_r, rx_slot_select_r, tx_cap_r, rx_cap_r;
	logic [7:0] baud_low_r, vec_base_r, ipc_r, cfg1_r, cfg2_r, cfg3_r, mask_r;
	logic [7:0] status_r, status_nxt, rdata;
	logic       carrier_q_r, lock_lost_q_r, ack_q_r;
	logic [7:0] local_ofs;
	logic       wr, rd, mapped;
	logic [7:0] ev, visible_pend;
	logic       pend_a0, any_pend;
	logic [4:0] summary;

	// channel B mirror: shared registers decode at either base
	assign local_ofs = (paddr[7:0] >= CHAN_B_OFS) ? paddr[7:0] - CHAN_B_OFS : paddr[7:0];
	assign wr = psel & penable & pwrite & clk_en;
	assign rd = psel & penable & ~pwrite & clk_en;

	// writes to control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_slot_select_r <= REG_RESET;
			rx_slot_select_r <= REG_RESET;
			tx_cap_r         <= REG_RESET;
			rx_cap_r         <= REG_RESET;
			baud_low_r       <= REG_RESET;
			vec_base_r       <= REG_RESET;
			ipc_r            <= REG_RESET;
			cfg1_r           <= REG_RESET;
			cfg2_r           <= REG_RESET;
			cfg3_r           <= REG_RESET;
			mask_r           <= MASK_RESET;
		end else if (wr) begin
			case (local_ofs)
				TX_SLOT_SELECT_OFS:   tx_slot_select_r <= pwdata[7:0];
				RX_SLOT_SELECT_OFS:   rx_slot_select_r <= pwdata[7:0];
				TX_SLOT_CAPACITY_OFS: tx_cap_r <= pwdata[7:0];
				RX_SLOT_CAPACITY_OFS: rx_cap_r <= pwdata[7:0];
				REV_STATUS_OFS:       baud_low_r <= pwdata[7:0];
				GLOBAL_SUMMARY_OFS:   vec_base_r <= {pwdata[7:3], 3'b000};
				IRQ_OUTPUT_CFG_OFS:   ipc_r <= pwdata[7:0] & 8'h9f;
				CHAN_CONFIG1_OFS:     cfg1_r <= pwdata[7:0];
				CHAN_CONFIG2_OFS:     cfg2_r <= pwdata[7:0];
				CHAN_CONFIG3_OFS:     cfg3_r <= pwdata[7:0];
				MASK_REG0_OFS:        mask_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// event sources; the set terms win over the read clear
	always_comb begin
		ev = 8'h00;
		ev[EV_TERM]      = term_char_in & short_block;
		ev[EV_PARITY]    = parity_fault_in;
		ev[EV_SYNC]      = hunt_mode & sync_char_in;
		ev[EV_LOCK_LOST] = recovery_unlocked & ~lock_lost_q_r & rx_clk_from_recovery;
		ev[EV_CARRIER]   = carrier_sense ^ carrier_q_r;
		ev[EV_OVERFLOW]  = queue_full & char_arrived;
		ev[EV_THRESHOLD] = interrupt_mode & queue_at_threshold;
	end

	// masked events only recorded when visible is set
	always_comb begin
		status_nxt = status_r;
		if (rd && local_ofs == RX_EVENT_STATUS_OFS)
			status_nxt = 8'h00;
		if (ack_vector_oe)
			status_nxt = status_nxt & ~(8'h01 << EV_TERM) & ~(8'h01 << EV_THRESHOLD);
		status_nxt = status_nxt | (ev & (~mask_r | {8{ipc_r[7]}}));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r      <= REG_RESET;
			carrier_q_r   <= 1'b0;
			lock_lost_q_r <= 1'b0;
		end else if (clk_en) begin
			status_r      <= status_nxt;
			carrier_q_r   <= carrier_sense;
			lock_lost_q_r <= recovery_unlocked;
		end
	end

	// pending only through unmasked bits; read of status clears its summary bit
	assign visible_pend = status_r & ~mask_r;
	assign pend_a0 = |visible_pend;
	assign summary = {port_irq_in, chan_a_status1_in, pend_a0, chan_b_status1_in, chan_b_status0_in};
	assign any_pend = |summary;

	// read mux
	always_comb begin
		rdata  = 8'h00;
		mapped = 1'b1;
		case (local_ofs)
			REV_STATUS_OFS:      rdata = {carrier_sense, recovery_unlocked, 2'b00, 4'h0};
			GLOBAL_SUMMARY_OFS:  rdata = {summary[4], 3'b000, summary[3:0]};
			IRQ_OUTPUT_CFG_OFS:  rdata = ipc_r;
			RX_EVENT_STATUS_OFS: rdata = status_r;
			CHAN_CONFIG1_OFS:    rdata = cfg1_r;
			CHAN_CONFIG2_OFS:    rdata = cfg2_r;
			CHAN_CONFIG3_OFS:    rdata = cfg3_r;
			EXT_STATUS_OFS:      rdata = {7'h00, sync_state};
			TX_SLOT_SELECT_OFS, RX_SLOT_SELECT_OFS, TX_SLOT_CAPACITY_OFS, RX_SLOT_CAPACITY_OFS: rdata = 8'h00;
			default:             mapped = 1'b0;
		endcase
	end

	// apb answer: zero wait, registered one cycle in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;
		end
	end

	// interrupt stage, cascade and vector output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out          <= 1'b0;
			irq_oe           <= 1'b0;
			chain_enable_out <= 1'b1;
			ack_vector_oe    <= 1'b0;
			ack_vector       <= 8'h00;
			ack_q_r          <= 1'b0;
		end else if (clk_en) begin
			ack_q_r <= irq_ack;
			case (ipc_r[1:0])
				2'b01:   begin irq_out <= ~any_pend; irq_oe <= 1'b1; end
				2'b11:   begin irq_out <= any_pend;  irq_oe <= 1'b1; end
				default: begin irq_out <= 1'b0;      irq_oe <= any_pend; end
			endcase
			chain_enable_out <= ipc_r[2] ? ~any_pend & enable_pin_one : 1'b1;
			if (irq_ack && !ack_q_r && any_pend &&
			    (ipc_r[2] ? enable_pin_one : {enable_pin_one, enable_pin_zero} == ipc_r[4:3])) begin
				ack_vector_oe <= 1'b1;
				ack_vector    <= {vec_base_r[7:3], 3'b000};
			end else if (!irq_ack) begin
				ack_vector_oe <= 1'b0;
			end
		end
	end

	// datapath control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poly_ccitt      <= 1'b0;
			phase_shift_off <= 1'b0;
			slot_mode_on    <= 1'b0;
			tx_slot_number  <= 6'h00;
			rx_slot_number  <= 6'h00;
			tx_offset       <= 3'h0;
			rx_offset       <= 3'h0;
			tx_slot_bits    <= 9'h001;
			rx_slot_bits    <= 9'h001;
			baud_divide     <= 12'h002;
			rx_idle_fill    <= 1'b0;
			tx_halt         <= 1'b0;
			sync_state      <= 1'b0;
		end else if (clk_en) begin
			poly_ccitt      <= cfg3_r[1];
			// coding type is not held here; the receive path applies it only for nrz/nrzi
			phase_shift_off <= cfg3_r[0];
			slot_mode_on    <= cfg1_r[2:0] == CLOCK_MODE_SLOT;
			if (cfg1_r[2:0] == CLOCK_MODE_SLOT) begin
				tx_slot_number <= tx_slot_select_r[7:2];
				rx_slot_number <= rx_slot_select_r[7:2];
				tx_offset      <= {tx_slot_select_r[1:0], cfg2_r[5]};
				rx_offset      <= {rx_slot_select_r[1:0], cfg2_r[4]};
				tx_slot_bits   <= {1'b0, tx_cap_r} + 9'h001;
				rx_slot_bits   <= {1'b0, rx_cap_r} + 9'h001;
			end
			// twelve bits: the largest divisor, 2048, does not fit in eleven
			baud_divide  <= {1'b0, cfg2_r[7:6], baud_low_r, 1'b0} + 12'h002;
			rx_idle_fill <= recovery_unlocked & rx_clk_from_recovery;
			tx_halt      <= recovery_unlocked & tx_clk_from_recovery;
			if (ev[EV_SYNC])
				sync_state <= 1'b1;
		end
	end

	property p_vector_base;
		@(posedge pclk) disable iff (!presetn)
		$rose(ack_vector_oe) |-> ack_vector[7:3] == $past(vec_base_r[7:3]) && ack_vector[2:0] == 3'b000;
	endproperty
	a_vector_base: assert property (p_vector_base) else $error("vector base not on bits 7..3");

	property p_summary_hold;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rd && local_ofs == GLOBAL_SUMMARY_OFS && pend_a0 && !ack_vector_oe |=> pend_a0;
	endproperty
	a_summary_hold: assert property (p_summary_hold) else $error("summary cleared by its own read");

	property p_read_clear;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rd && local_ofs == RX_EVENT_STATUS_OFS && ev == 8'h00 |=> status_r == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

	property p_carrier_change;
		@(posedge pclk) disable iff (!presetn)
		clk_en && carrier_sense != carrier_q_r && (!mask_r[EV_CARRIER] || ipc_r[7]) |=> status_r[EV_CARRIER];
	endproperty
	a_carrier_change: assert property (p_carrier_change) else $error("carrier change not recorded");

	property p_masked_silent;
		@(posedge pclk) disable iff (!presetn)
		(status_r & ~mask_r) == 8'h00 && summary[3:0] == 4'h0 && !summary[4] && clk_en |=>
			(ipc_r[1:0] == 2'b11 ? !irq_out : 1'b1);
	endproperty
	a_masked_silent: assert property (p_masked_silent) else $error("masked status drove interrupt");

	property p_irq_active;
		@(posedge pclk) disable iff (!presetn)
		clk_en && any_pend && ipc_r[1:0] == 2'b11 |=> irq_out && irq_oe;
	endproperty
	a_irq_active: assert property (p_irq_active) else $error("interrupt not raised");

	property p_chain_low;
		@(posedge pclk) disable iff (!presetn)
		clk_en && ipc_r[2] && any_pend |=> !chain_enable_out;
	endproperty
	a_chain_low: assert property (p_chain_low) else $error("chain enable out not low");

	property p_baud;
		@(posedge pclk) disable iff (!presetn)
		clk_en ##1 1'b1 |-> baud_divide == ({1'b0, $past(cfg2_r[7:6]), $past(baud_low_r), 1'b0} + 12'h002);
	endproperty
	a_baud: assert property (p_baud) else $error("baud divide wrong");

	property p_threshold_mode;
		@(posedge pclk) disable iff (!presetn)
		!interrupt_mode |-> !ev[EV_THRESHOLD];
	endproperty
	a_threshold_mode: assert property (p_threshold_mode) else $error("threshold outside interrupt mode");

	property p_poly;
		@(posedge pclk) disable iff (!presetn)
		clk_en |=> poly_ccitt == $past(cfg3_r[1]);
	endproperty
	a_poly: assert property (p_poly) else $error("polynomial select not followed");

	property p_phase_off;
		@(posedge pclk) disable iff (!presetn)
		clk_en |=> phase_shift_off == $past(cfg3_r[0]);
	endproperty
	a_phase_off: assert property (p_phase_off) else $error("phase shift disable not followed");

	// slot settings must not leak into the datapath outside mode five
	property p_slot_ignored;
		@(posedge pclk) disable iff (!presetn)
		clk_en && cfg1_r[2:0] != CLOCK_MODE_SLOT |=> $stable(tx_slot_number) && $stable(rx_slot_bits);
	endproperty
	a_slot_ignored: assert property (p_slot_ignored) else $error("slot settings applied outside mode five");

	property p_slot_bits;
		@(posedge pclk) disable iff (!presetn)
		clk_en && cfg1_r[2:0] == CLOCK_MODE_SLOT |=> tx_slot_bits == {1'b0, $past(tx_cap_r)} + 9'h001;
	endproperty
	a_slot_bits: assert property (p_slot_bits) else $error("slot bit count not count plus one");

	property p_ack_refused;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !any_pend && !ack_vector_oe |=> !ack_vector_oe;
	endproperty
	a_ack_refused: assert property (p_ack_refused) else $error("vector driven with nothing pending");

	property p_idle_fill;
		@(posedge pclk) disable iff (!presetn)
		clk_en |=> rx_idle_fill == ($past(recovery_unlocked) && $past(rx_clk_from_recovery));
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("idle fill not following lock loss");

	property p_sync_found;
		@(posedge pclk) disable iff (!presetn)
		clk_en && hunt_mode && sync_char_in |=> sync_state;
	endproperty
	a_sync_found: assert property (p_sync_found) else $error("sync state not entered");

	property p_overflow;
		@(posedge pclk) disable iff (!presetn)
		clk_en && queue_full && char_arrived && (!mask_r[EV_OVERFLOW] || ipc_r[7]) |=> status_r[EV_OVERFLOW];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not recorded");
endmodule : scsirq_regs
`default_nettype wire

// ===== scsirq_host.sv
// host model: apb master issuing one register cycle at a time
`timescale 1ns/1ns
`default_nettype none
module scsirq_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic             hung
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		hung = 1'b0;
	end
	// setup, then access held until pready is seen at an edge; bounded so a dead slave ends the run
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		psel <= 1'b0;
		penable <= 1'b0;
		hung <= (n >= 16);
	endtask : xfer
endmodule : scsirq_host
`default_nettype wire

// ===== scsirq_regs_tb.sv
// self-checking bench for the channel status and interrupt register bank
`timescale 1ns/1ns
`default_nettype none
module scsirq_regs_tb;
	import scsirq_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, hung;
	logic [7:0]  paddr, vec, v, c;
	logic [31:0] pwdata, prdata;
	logic        carrier = 1'b0, unl = 1'b0, rec = 1'b0, hunt = 1'b0, imode = 1'b1;
	logic        ack = 1'b0, pin0 = 1'b0, pin1 = 1'b0, en = 1'b1;
	logic [3:0]  pend = 4'h0;
	logic [4:0]  ev = 5'h00;
	logic        cen, iout, ioe, voe, poly, pso, slot, idle, halt, sync;
	logic [5:0]  tsn, rsn;
	logic [2:0]  tof, rof;
	logic [8:0]  tbits, rbits;
	logic [11:0] baud;
	logic [9:0]  e;
	logic [9:0]  q[$];
	logic [7:0]  eb[5] = '{8'h80, 8'h10, 8'h01, 8'h02, 8'h20};
	logic [7:0]  st[4] = '{8'h00, 8'h01, 8'h03, 8'h02};
	int          miscompares = 0, comparisons = 0;

	scsirq_host i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .hung(hung));
	scsirq_regs i_dut (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.carrier_sense(carrier), .recovery_unlocked(unl), .rx_clk_from_recovery(rec), .tx_clk_from_recovery(rec),
		.term_char_in(ev[0]), .short_block(ev[0]), .hunt_mode(hunt), .sync_char_in(ev[1]),
		.parity_fault_in(ev[4]), .queue_at_threshold(ev[2]), .queue_full(ev[3]), .char_arrived(ev[3]),
		.interrupt_mode(imode), .chan_a_status1_in(pend[2]), .chan_b_status0_in(pend[0]),
		.chan_b_status1_in(pend[1]), .port_irq_in(pend[3]), .irq_ack(ack), .enable_pin_zero(pin0),
		.enable_pin_one(pin1), .chain_enable_out(cen), .irq_out(iout), .irq_oe(ioe), .ack_vector_oe(voe),
		.ack_vector(vec), .poly_ccitt(poly), .phase_shift_off(pso), .slot_mode_on(slot),
		.tx_slot_number(tsn), .rx_slot_number(rsn), .tx_offset(tof), .rx_offset(rof), .tx_slot_bits(tbits),
		.rx_slot_bits(rbits), .baud_divide(baud), .rx_idle_fill(idle), .tx_halt(halt), .sync_state(sync));

	always #25 pclk = ~pclk;
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(string n, logic [11:0] x, logic [11:0] g);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// reads note the expectation: bit 9 means data is compared, bit 8 is the error flag
	task automatic rd(logic [7:0] a, logic [9:0] x);
		q.push_back(x);
		i_host.xfer(1'b0, a, 8'h00);
	endtask : rd
	task automatic wr(logic [7:0] a, logic [7:0] d);
		i_host.xfer(1'b1, a, d);
	endtask : wr
	// one-cycle event pulse, then time for status to settle
	task automatic pulse(logic [4:0] p);
		ev <= p;
		tick(1);
		ev <= 5'h00;
		tick(2);
	endtask : pulse
	task automatic acknowledge(logic x);
		ack <= 1'b1;
		tick(2);
		chk("vec_oe", x, voe);
		if (x) chk("vec", v[7:3], vec[7:3]);
		ack <= 1'b0;
		tick(2);
	endtask : acknowledge
	// read monitor takes the oldest note at the completing edge
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
			e = q.pop_front();
			chk("read", {e[8], e[7:0] & {8{e[9]}}}, {pslverr, prdata[7:0] & {8{e[9]}}});
		end
	end
	// a hung bus counts against the run
	always @(posedge hung) begin
		miscompares++;
		conclude();
	end

	initial begin
		v = 8'($urandom(2));
		c = 8'($urandom);
		tick(10);
		presetn <= 1'b1;
		chk("baud", 11'd2, baud);
		chk("tbits", 9'd1, tbits);
		chk("cen", 1'b1, cen);
		rd(GLOBAL_SUMMARY_OFS, 10'h200);
		rd(8'h00, 10'h100);
		$display("test reset done");
		wr(CHAN_CONFIG1_OFS, 8'h05);
		wr(CHAN_CONFIG2_OFS, 8'h20);
		wr(TX_SLOT_SELECT_OFS, v);
		wr(RX_SLOT_SELECT_OFS, c);
		wr(TX_SLOT_CAPACITY_OFS, c);
		wr(RX_SLOT_CAPACITY_OFS, v);
		tick(2);
		chk("slot", 1'b1, slot);
		chk("tsn", v[7:2], tsn);
		chk("rsn", c[7:2], rsn);
		chk("tof", {v[1:0], 1'b1}, tof);
		chk("rof", {c[1:0], 1'b0}, rof);
		chk("tbits", c + 9'd1, tbits);
		chk("rbits", v + 9'd1, rbits);
		wr(CHAN_CONFIG1_OFS, 8'h02);
		wr(TX_SLOT_SELECT_OFS, ~v);
		wr(CHAN_CONFIG2_OFS, 8'he0);
		wr(REV_STATUS_OFS, 8'hff);
		tick(2);
		chk("slot", 1'b0, slot);
		chk("tsn", v[7:2], tsn);
		chk("baud", 12'd2048, baud);
		for (int i = 0; i < 4; i++) begin
			wr(CHAN_CONFIG3_OFS, 8'(i));
			tick(2);
			chk("poly", i[1], poly);
			chk("pso", i[0], pso);
		end
		$display("test config done");
		wr(MASK_REG0_OFS, 8'h00);
		// an event while the clock enable is low must leave no trace
		en <= 1'b0;
		pulse(5'h08);
		en <= 1'b1;
		rd(RX_EVENT_STATUS_OFS, 10'h200);
		rec <= 1'b1;
		carrier <= 1'b1;
		tick(3);
		rd(REV_STATUS_OFS, 10'h280);
		rd(GLOBAL_SUMMARY_OFS, 10'h204);
		rd(GLOBAL_SUMMARY_OFS + CHAN_B_OFS, 10'h204);
		chk("ioe", 1'b1, ioe);
		rd(RX_EVENT_STATUS_OFS, 10'h204);
		rd(GLOBAL_SUMMARY_OFS, 10'h200);
		chk("ioe", 1'b0, ioe);
		unl <= 1'b1;
		tick(3);
		chk("idle", 1'b1, idle);
		chk("halt", 1'b1, halt);
		rd(REV_STATUS_OFS, 10'h2c0);
		rd(RX_EVENT_STATUS_OFS, 10'h208);
		unl <= 1'b0;
		hunt <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			pulse(5'(1 << i));
			rd(RX_EVENT_STATUS_OFS, {2'b10, eb[i]});
		end
		chk("sync", 1'b1, sync);
		wr(MASK_REG0_OFS, 8'hff);
		for (int i = 0; i < 2; i++) begin
			wr(IRQ_OUTPUT_CFG_OFS, {i[0], 7'h00});
			pulse(5'h01);
			chk("ioe", 1'b0, ioe);
			rd(GLOBAL_SUMMARY_OFS, 10'h200);
			rd(RX_EVENT_STATUS_OFS, {2'b10, i[0], 7'h00});
		end
		$display("test status done");
		wr(MASK_REG0_OFS, 8'h00);
		pend <= 4'hf;
		tick(2);
		rd(GLOBAL_SUMMARY_OFS, 10'h28b);
		pend <= 4'h8;
		foreach (st[k]) begin
			wr(IRQ_OUTPUT_CFG_OFS + CHAN_B_OFS, st[k]);
			rd(IRQ_OUTPUT_CFG_OFS, {2'b10, st[k]});
			chk("pin", {1'b1, st[k][1] & st[k][0]}, {ioe, iout});
			pend <= 4'h0;
			tick(3);
			chk("pin", {st[k][0], st[k][0] & ~st[k][1]}, {ioe, iout});
			pend <= 4'h8;
		end
		pend <= 4'h0;
		v = 8'($urandom) & 8'hf8;
		wr(GLOBAL_SUMMARY_OFS, v);
		wr(IRQ_OUTPUT_CFG_OFS, 8'h04);
		pulse(5'h0c);
		chk("cen", 1'b0, cen);
		pin1 <= 1'b1;
		acknowledge(1'b1);
		rd(RX_EVENT_STATUS_OFS, 10'h202);
		tick(2);
		chk("cen", 1'b1, cen);
		wr(IRQ_OUTPUT_CFG_OFS, 8'h18);
		pin1 <= 1'b0;
		pulse(5'h04);
		acknowledge(1'b0);
		pin0 <= 1'b1;
		pin1 <= 1'b1;
		acknowledge(1'b1);
		rd(RX_EVENT_STATUS_OFS, 10'h200);
		$display("test irq done");
		conclude();
	end
endmodule : scsirq_regs_tb
`default_nettype wire
